// *** inc/exec_pkg.sv ***
/*
 * Constants and types shared by the move, multiply, extend and branch
 * execution unit: operation codes, condition codes, flag positions,
 * register numbers, branch offset widths and the register map.
 * Assumes a 32-bit datapath and a 16-bit instruction granule.
 */
package exec_pkg;

	// -------------------------------------------------------------
	// Operations issued by the decode stage
	// -------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_COPY_REGISTER = 5'h01,
		OP_COPY_REGISTER_SETFLAGS = 5'h02,
		OP_COPY_IMMEDIATE = 5'h03,
		OP_COPY_INVERTED = 5'h04,
		OP_MULTIPLY_LOW_WORD = 5'h05,
		OP_BYTE_ORDER_SWAP_WORD = 5'h06,
		OP_BYTE_ORDER_SWAP_HALVES = 5'h07,
		OP_BYTE_ORDER_SWAP_SIGNED_HALF = 5'h08,
		OP_SIGN_EXTEND_BYTE = 5'h09,
		OP_SIGN_EXTEND_HALFWORD = 5'h0a,
		OP_ZERO_EXTEND_BYTE = 5'h0b,
		OP_ZERO_EXTEND_HALFWORD = 5'h0c,
		OP_BIT_TEST_AND = 5'h0d,
		OP_BRANCH = 5'h0e,
		OP_BRANCH_COND = 5'h0f,
		OP_BRANCH_WITH_LINK = 5'h10,
		OP_BRANCH_INDIRECT = 5'h11,
		OP_BRANCH_INDIRECT_LINK = 5'h12
	} op_t;

	// -------------------------------------------------------------
	// Condition codes
	// -------------------------------------------------------------
	localparam logic [3:0] COND_EQ = 4'h0;
	localparam logic [3:0] COND_NE = 4'h1;
	localparam logic [3:0] COND_CS = 4'h2;
	localparam logic [3:0] COND_CC = 4'h3;
	localparam logic [3:0] COND_MI = 4'h4;
	localparam logic [3:0] COND_PL = 4'h5;
	localparam logic [3:0] COND_VS = 4'h6;
	localparam logic [3:0] COND_VC = 4'h7;
	localparam logic [3:0] COND_HI = 4'h8;
	localparam logic [3:0] COND_LS = 4'h9;
	localparam logic [3:0] COND_GE = 4'ha;
	localparam logic [3:0] COND_LT = 4'hb;
	localparam logic [3:0] COND_GT = 4'hc;
	localparam logic [3:0] COND_LE = 4'hd;

	// -------------------------------------------------------------
	// Flags, registers and address arithmetic
	// -------------------------------------------------------------
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_C = 1;
	localparam int FLAG_V = 0;
	localparam int FLAGS_T_BIT = 4;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [3:0] REG_LINK = 4'he;
	localparam logic [3:0] REG_PROGRAM_COUNTER = 4'hf;
	localparam logic [31:0] PC_READ_AHEAD = 32'h0000_0004;
	localparam logic [31:0] INSN_SIZE_SHORT = 32'h0000_0002;
	localparam logic [31:0] INSN_SIZE_LONG = 32'h0000_0004;
	localparam int OFS_W_BRANCH = 12;
	localparam int OFS_W_BRANCH_COND = 9;
	localparam int OFS_W_BRANCH_LINK = 25;

	// -------------------------------------------------------------
	// Register map, byte addresses
	// -------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_FLAGS = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_FAULT_PC = 4'hc;
	localparam int CTRL_HOLD_BIT = 0;
	localparam int STATUS_FAULT_BIT = 0;
	localparam int STATUS_COUNT_LSB = 8;

endpackage : exec_pkg

// *** hw/move_mul_extend_branch_exec.sv ***
/*
 * Execution unit for register and immediate copies, inverted copy, low
 * word multiply, byte order swaps, extends, bit test and the direct and
 * indirect branches with optional link. Condition flags and the state
 * bit live here and are reachable over an Avalon-MM slave.
 * Assumes the decode stage supplies operand values read from the
 * register file, the instruction address and a sign-carrying offset,
 * and writes back the registered result one cycle after issue.
 */
// Functional notes
// RQ1: Plain copy writes source unchanged to destination, flags untouched.
// RQ2: Flag-setting copy or inverted copy sets N and Z, keeps C and V.
// RQ3: Inverted copy writes the bitwise complement of the source.
// RQ4: Immediate flag-setting copy writes an 8-bit constant zero-extended.
// RQ5: Copy to program counter branches with bit 0 cleared, state bit kept.
// RQ6: Multiply writes only the low 32 bits of the product.
// RQ7: Multiply low word needs no signedness control.
// RQ8: Multiply sets N and Z from the result, keeps C and V.
// RQ9: Word byte swap reverses all four bytes of the source.
// RQ10: Halves byte swap swaps bytes inside each 16-bit half.
// RQ11: Signed half swap swaps low half bytes and sign-extends to 32 bits.
// RQ12: All byte swaps leave every flag unchanged.
// RQ13: Extends take bits 7:0 or 15:0, sign or zero extended to 32.
// RQ14: Extends leave every flag unchanged.
// RQ15: Bit test ANDs two registers, writes nothing, sets N and Z only.
// RQ16: Linking branches write next address with bit 0 set into R14.
// RQ17: Indirect branches fault instead of branching when target bit 0 is 0.
// RQ18: Indirect branches load target bit 0 into state bit, branch without it.
// RQ19: Offsets reach 2 KB, -256..+254 bytes conditional, 16 MB with link.
// RQ20: Conditional branch taken only when its condition holds.
// RQ21: Software never names stack pointer or counter as indirect target.
// RQ22: Software keeps multiply operands low and destination equal to Rm.
`timescale 1ns/1ns
module move_mul_extend_branch_exec
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic issue_valid,
	output logic issue_ready,
	input wire exec_pkg::op_t issue_op,
	input wire logic [3:0] issue_rd,
	input wire logic [31:0] issue_rn_val,
	input wire logic [31:0] issue_rm_val,
	input wire logic [7:0] issue_imm8,
	input wire logic [3:0] issue_cond,
	input wire logic [24:0] issue_offset,
	input wire logic [31:0] issue_pc,
	output logic wr_en,
	output logic [3:0] wr_addr,
	output logic [31:0] wr_data,
	output logic branch_valid,
	output logic [31:0] branch_target,
	output logic unrecoverable_fault_exception,
	output logic [3:0] cond_flags,
	output logic t_state,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic issue_ready_reg;
	logic wr_en_reg;
	logic [3:0] wr_addr_reg;
	logic [31:0] wr_data_reg;
	logic branch_valid_reg;
	logic [31:0] branch_target_reg;
	logic fault_reg;
	logic [3:0] flags_reg;
	logic t_state_reg;
	logic ctrl_hold_reg;
	logic fault_sticky_reg;
	logic [31:0] fault_pc_reg;
	logic [23:0] op_count_reg;
	logic [31:0] readdata_reg;
	logic waitrequest_reg;

	logic fire;
	logic bus_wr;
	logic bus_flags_wr;
	logic [31:0] res;
	logic res_wr;
	logic [3:0] res_rd;
	logic nz_upd;
	logic br;
	logic [31:0] br_tgt;
	logic fault;
	logic t_upd;
	logic [31:0] pc_base;
	logic [31:0] mul_low;

	assign fire = issue_valid && issue_ready_reg;
	assign bus_wr = avs_write && !waitrequest_reg;
	assign bus_flags_wr = bus_wr && avs_address == exec_pkg::ADDR_FLAGS
		&& avs_byteenable[0];
	assign pc_base = issue_pc + exec_pkg::PC_READ_AHEAD;
	// The low word of a product is the same for signed and unsigned
	// operands, so one unsigned multiplier serves both.
	assign mul_low = 32'(issue_rn_val * issue_rm_val); // see RQ6 see RQ7

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] sext_ofs(input logic [24:0] v,
		input int w);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 32; i++)
		begin
			r[i] = (i < w) ? v[i] : v[w - 1];
		end
		return r;
	endfunction : sext_ofs

	function automatic logic cond_true(input logic [3:0] c,
		input logic [3:0] f);
		logic n;
		logic z;
		logic cy;
		logic v;
		logic t;
		n = f[exec_pkg::FLAG_N];
		z = f[exec_pkg::FLAG_Z];
		cy = f[exec_pkg::FLAG_C];
		v = f[exec_pkg::FLAG_V];
		case (c)
			exec_pkg::COND_EQ: t = z;
			exec_pkg::COND_NE: t = !z;
			exec_pkg::COND_CS: t = cy;
			exec_pkg::COND_CC: t = !cy;
			exec_pkg::COND_MI: t = n;
			exec_pkg::COND_PL: t = !n;
			exec_pkg::COND_VS: t = v;
			exec_pkg::COND_VC: t = !v;
			exec_pkg::COND_HI: t = cy && !z;
			exec_pkg::COND_LS: t = !cy || z;
			exec_pkg::COND_GE: t = n == v;
			exec_pkg::COND_LT: t = n != v;
			exec_pkg::COND_GT: t = !z && n == v;
			exec_pkg::COND_LE: t = z || n != v;
			default: t = 1'b1;
		endcase
		return t;
	endfunction : cond_true

	// ------------------------------------------------------------
	// Operation decode and datapath
	// ------------------------------------------------------------
	always_comb
	begin
		res = issue_rm_val;
		res_wr = 1'b0;
		res_rd = issue_rd;
		nz_upd = 1'b0;
		br = 1'b0;
		br_tgt = '0;
		fault = 1'b0;
		t_upd = 1'b0;
		case (issue_op)
			exec_pkg::OP_COPY_REGISTER:
			begin
				if (issue_rd == exec_pkg::REG_PROGRAM_COUNTER)
				begin
					br = 1'b1; // see RQ5
					br_tgt = {issue_rm_val[31:1], 1'b0}; // see RQ5
				end
				else
				begin
					res_wr = 1'b1; // see RQ1
				end
			end
			exec_pkg::OP_COPY_REGISTER_SETFLAGS:
			begin
				res_wr = 1'b1;
				nz_upd = 1'b1; // see RQ2
			end
			exec_pkg::OP_COPY_IMMEDIATE:
			begin
				res = {24'h00_0000, issue_imm8}; // see RQ4
				res_wr = 1'b1;
				nz_upd = 1'b1; // see RQ2
			end
			exec_pkg::OP_COPY_INVERTED:
			begin
				res = ~issue_rm_val; // see RQ3
				res_wr = 1'b1;
				nz_upd = 1'b1; // see RQ2
			end
			exec_pkg::OP_MULTIPLY_LOW_WORD:
			begin
				res = mul_low; // see RQ22
				res_wr = 1'b1;
				nz_upd = 1'b1; // see RQ8
			end
			exec_pkg::OP_BYTE_ORDER_SWAP_WORD:
			begin
				res = {issue_rm_val[7:0], issue_rm_val[15:8],
					issue_rm_val[23:16], issue_rm_val[31:24]}; // see RQ9
				res_wr = 1'b1; // see RQ12
			end
			exec_pkg::OP_BYTE_ORDER_SWAP_HALVES:
			begin
				res = {issue_rm_val[23:16], issue_rm_val[31:24],
					issue_rm_val[7:0], issue_rm_val[15:8]}; // see RQ10
				res_wr = 1'b1; // see RQ12
			end
			exec_pkg::OP_BYTE_ORDER_SWAP_SIGNED_HALF:
			begin
				res = {{16{issue_rm_val[7]}}, issue_rm_val[7:0],
					issue_rm_val[15:8]}; // see RQ11
				res_wr = 1'b1; // see RQ12
			end
			exec_pkg::OP_SIGN_EXTEND_BYTE:
			begin
				res = {{24{issue_rm_val[7]}}, issue_rm_val[7:0]}; // see RQ13
				res_wr = 1'b1; // see RQ14
			end
			exec_pkg::OP_SIGN_EXTEND_HALFWORD:
			begin
				res = {{16{issue_rm_val[15]}}, issue_rm_val[15:0]}; // see RQ13
				res_wr = 1'b1; // see RQ14
			end
			exec_pkg::OP_ZERO_EXTEND_BYTE:
			begin
				res = {24'h00_0000, issue_rm_val[7:0]}; // see RQ13
				res_wr = 1'b1; // see RQ14
			end
			exec_pkg::OP_ZERO_EXTEND_HALFWORD:
			begin
				res = {16'h0000, issue_rm_val[15:0]}; // see RQ13
				res_wr = 1'b1; // see RQ14
			end
			exec_pkg::OP_BIT_TEST_AND:
			begin
				res = issue_rn_val & issue_rm_val; // see RQ15
				nz_upd = 1'b1; // see RQ15
			end
			exec_pkg::OP_BRANCH:
			begin
				br = 1'b1;
				br_tgt = pc_base + sext_ofs(issue_offset,
					exec_pkg::OFS_W_BRANCH); // see RQ19
			end
			exec_pkg::OP_BRANCH_COND:
			begin
				br = cond_true(issue_cond, flags_reg); // see RQ20
				br_tgt = pc_base + sext_ofs(issue_offset,
					exec_pkg::OFS_W_BRANCH_COND); // see RQ19
			end
			exec_pkg::OP_BRANCH_WITH_LINK:
			begin
				br = 1'b1;
				br_tgt = pc_base + sext_ofs(issue_offset,
					exec_pkg::OFS_W_BRANCH_LINK); // see RQ19
				res = (issue_pc + exec_pkg::INSN_SIZE_LONG) | 32'h0000_0001;
				res_rd = exec_pkg::REG_LINK; // see RQ16
				res_wr = 1'b1;
			end
			exec_pkg::OP_BRANCH_INDIRECT,
			exec_pkg::OP_BRANCH_INDIRECT_LINK:
			begin
				// A faulting indirect branch neither branches nor links, so
				// the handler sees the register file as it was.
				fault = !issue_rm_val[0]; // see RQ17 see RQ21
				br = issue_rm_val[0];
				t_upd = issue_rm_val[0]; // see RQ18
				br_tgt = {issue_rm_val[31:1], 1'b0}; // see RQ18
				res = (issue_pc + exec_pkg::INSN_SIZE_SHORT)
					| 32'h0000_0001; // see RQ16
				res_rd = exec_pkg::REG_LINK;
				res_wr = issue_rm_val[0]
					&& issue_op == exec_pkg::OP_BRANCH_INDIRECT_LINK;
			end
			default:
			begin
				res = issue_rm_val;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_en_reg <= 1'b0;
			wr_addr_reg <= 4'h0;
			wr_data_reg <= 32'h0000_0000;
			branch_valid_reg <= 1'b0;
			branch_target_reg <= 32'h0000_0000;
			fault_reg <= 1'b0;
		end
		else
		begin
			wr_en_reg <= fire && res_wr;
			branch_valid_reg <= fire && br;
			fault_reg <= fire && fault;
			if (fire)
			begin
				wr_addr_reg <= res_rd;
				wr_data_reg <= res;
				branch_target_reg <= br_tgt;
			end
		end
	end

	// ------------------------------------------------------------
	// Flags and state bit
	// ------------------------------------------------------------
	// An operation that sets the flags or the state bit takes priority over a bus write in the
	// same cycle; the bus write is then lost for that register.
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			flags_reg <= exec_pkg::FLAGS_RESET;
		end
		else if (fire && nz_upd)
		begin
			flags_reg[exec_pkg::FLAG_N] <= res[31]; // see RQ2 see RQ8
			flags_reg[exec_pkg::FLAG_Z] <= res == 32'h0000_0000; // see RQ15
		end
		else if (bus_flags_wr)
		begin
			flags_reg <= avs_writedata[3:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			t_state_reg <= 1'b1;
		end
		else if (fire && t_upd)
		begin
			t_state_reg <= issue_rm_val[0]; // see RQ18
		end
		else if (bus_flags_wr)
		begin
			t_state_reg <= avs_writedata[exec_pkg::FLAGS_T_BIT];
		end
	end

	// ------------------------------------------------------------
	// Control, status and issue handshake
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_hold_reg <= 1'b0;
			issue_ready_reg <= 1'b0;
		end
		else
		begin
			issue_ready_reg <= !ctrl_hold_reg;
			if (bus_wr && avs_address == exec_pkg::ADDR_CTRL
				&& avs_byteenable[0])
			begin
				ctrl_hold_reg <= avs_writedata[exec_pkg::CTRL_HOLD_BIT];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			fault_sticky_reg <= 1'b0;
			fault_pc_reg <= 32'h0000_0000;
			op_count_reg <= 24'h00_0000;
		end
		else
		begin
			if (fire)
			begin
				op_count_reg <= op_count_reg + 24'h00_0001;
			end
			// A fault in the clearing cycle keeps the bit set.
			if (fire && fault)
			begin
				fault_sticky_reg <= 1'b1; // see RQ17
				fault_pc_reg <= issue_pc;
			end
			else if (bus_wr && avs_address == exec_pkg::ADDR_STATUS
				&& avs_byteenable[0]
				&& avs_writedata[exec_pkg::STATUS_FAULT_BIT])
			begin
				fault_sticky_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Avalon-MM slave: one wait cycle, then the answer
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			waitrequest_reg <= 1'b1;
			readdata_reg <= 32'h0000_0000;
		end
		else if (!waitrequest_reg)
		begin
			waitrequest_reg <= 1'b1;
		end
		else if (avs_read || avs_write)
		begin
			waitrequest_reg <= 1'b0;
			case (avs_address)
				exec_pkg::ADDR_FLAGS:
					readdata_reg <= {27'h000_0000, t_state_reg, flags_reg};
				exec_pkg::ADDR_CTRL:
					readdata_reg <= {31'h0000_0000, ctrl_hold_reg};
				exec_pkg::ADDR_STATUS:
					readdata_reg <= {op_count_reg, 7'h00, fault_sticky_reg};
				exec_pkg::ADDR_FAULT_PC:
					readdata_reg <= fault_pc_reg;
				default:
					readdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	assign issue_ready = issue_ready_reg;
	assign wr_en = wr_en_reg;
	assign wr_addr = wr_addr_reg;
	assign wr_data = wr_data_reg;
	assign branch_valid = branch_valid_reg;
	assign branch_target = branch_target_reg;
	assign unrecoverable_fault_exception = fault_reg;
	assign cond_flags = flags_reg;
	assign t_state = t_state_reg;
	assign avs_readdata = readdata_reg;
	assign avs_waitrequest = waitrequest_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_COPY_PLAIN: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ1
		fire && issue_op == exec_pkg::OP_COPY_REGISTER
		&& issue_rd != exec_pkg::REG_PROGRAM_COUNTER && !bus_flags_wr
		|=> wr_en && wr_data == $past(issue_rm_val) && $stable(flags_reg))
		else $error("plain copy wrong result or flags moved");
	AST_NZ_KEEP_CV: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ2
		fire && nz_upd |=> flags_reg[exec_pkg::FLAG_N] == wr_data[31]
		&& flags_reg[exec_pkg::FLAG_Z] == (wr_data == 32'h0000_0000)
		&& flags_reg[1:0] == $past(flags_reg[1:0]))
		else $error("flag setting form changed C or V or wrong N Z");
	AST_INVERT: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ3
		fire && issue_op == exec_pkg::OP_COPY_INVERTED
		|=> wr_en && (wr_data ^ $past(issue_rm_val)) == 32'hffff_ffff)
		else $error("inverted copy not complemented");
	AST_IMM8: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ4
		fire && issue_op == exec_pkg::OP_COPY_IMMEDIATE
		|=> wr_data[31:8] == 24'h00_0000 && wr_data[7:0] == $past(issue_imm8))
		else $error("immediate copy not zero extended");
	AST_COPY_TO_PC: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ5
		fire && issue_op == exec_pkg::OP_COPY_REGISTER
		&& issue_rd == exec_pkg::REG_PROGRAM_COUNTER && !bus_flags_wr
		|=> branch_valid && !wr_en && !branch_target[0]
		&& branch_target[31:1] == $past(issue_rm_val[31:1])
		&& $stable(t_state))
		else $error("copy to program counter mishandled");
	AST_MUL: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ6
		fire && issue_op == exec_pkg::OP_MULTIPLY_LOW_WORD
		|=> wr_data == 32'($past(issue_rn_val) * $past(issue_rm_val))
		&& flags_reg[exec_pkg::FLAG_N] == wr_data[31])
		else $error("multiply low word or N flag wrong");
	AST_SWAP_WORD: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ9
		fire && issue_op == exec_pkg::OP_BYTE_ORDER_SWAP_WORD
		&& !bus_flags_wr
		|=> wr_data[31:24] == $past(issue_rm_val[7:0])
		&& wr_data[7:0] == $past(issue_rm_val[31:24]) && $stable(flags_reg))
		else $error("word byte swap wrong");
	AST_SWAP_SIGNED: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ11
		fire && issue_op == exec_pkg::OP_BYTE_ORDER_SWAP_SIGNED_HALF
		|=> $signed(wr_data) == $signed($past({issue_rm_val[7:0],
		issue_rm_val[15:8]})))
		else $error("signed half swap wrong");
	AST_TEST_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ15
		fire && issue_op == exec_pkg::OP_BIT_TEST_AND
		|=> !wr_en && flags_reg[exec_pkg::FLAG_Z]
		== (($past(issue_rn_val) & $past(issue_rm_val)) == '0))
		else $error("bit test wrote a register or Z wrong");
	AST_LINK: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ16
		fire && issue_op == exec_pkg::OP_BRANCH_WITH_LINK
		|=> wr_en && wr_addr == exec_pkg::REG_LINK && wr_data[0]
		&& wr_data[31:1] == $past(issue_pc[31:1]) + 31'h0000_0002)
		else $error("link value wrong");
	AST_INDIRECT_FAULT: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ17
		fire && !issue_rm_val[0]
		&& (issue_op == exec_pkg::OP_BRANCH_INDIRECT
		|| issue_op == exec_pkg::OP_BRANCH_INDIRECT_LINK)
		|=> unrecoverable_fault_exception && !branch_valid && !wr_en
		##1 !unrecoverable_fault_exception || $past(fire))
		else $error("indirect branch with clear bit 0 did not fault");
	AST_INDIRECT_T: assert property (@(posedge clk_sys) disable iff (!nrst) // see RQ18
		fire && issue_rm_val[0] && issue_op == exec_pkg::OP_BRANCH_INDIRECT
		|=> branch_valid && t_state && !branch_target[0])
		else $error("indirect branch state bit or target wrong");
	AST_COND_NOT_TAKEN: assert property (@(posedge clk_sys) // see RQ20
		disable iff (!nrst)
		fire && issue_op == exec_pkg::OP_BRANCH_COND
		&& !cond_true(issue_cond, flags_reg) |=> !branch_valid)
		else $error("conditional branch taken on false condition");

endmodule : move_mul_extend_branch_exec

// *** test/reg_file_model.sv ***
/*
 * Register file model on the far side of the execution unit.
 * Assumes write-back arrives as a one-cycle pulse sampled on clk_sys.
 */
`timescale 1ns/1ns
module reg_file_model
(
	input wire logic clk_sys,
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] rd_sel,
	output logic [31:0] rd_val
);
	logic [31:0] regs [16];

	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
			regs[wr_addr] <= wr_data;
	end
	assign rd_val = regs[rd_sel];
endmodule : reg_file_model

// *** test/move_mul_extend_branch_exec_bench.sv ***
/*
 * Self-checking bench for the move, multiply, extend and branch unit.
 * Assumes the register file model stands on the write-back port.
 */
`timescale 1ns/1ns
module move_mul_extend_branch_exec_bench;
	logic clk_sys = 1'b0, nrst = 1'b0, issue_valid = 1'b0;
	logic avs_read = 1'b0, avs_write = 1'b0;
	exec_pkg::op_t issue_op = exec_pkg::OP_NONE;
	logic [3:0] issue_rd = 4'h0, issue_cond = 4'h0, avs_address = 4'h0;
	logic [31:0] issue_rn_val = 32'h0, issue_rm_val = 32'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [7:0] issue_imm8 = 8'h0;
	logic [24:0] issue_offset = 25'h0;
	logic issue_ready, wr_en, branch_valid, unrecoverable_fault_exception;
	logic t_state, avs_waitrequest;
	logic [3:0] wr_addr, cond_flags;
	logic [31:0] wr_data, branch_target, avs_readdata, rf_val, q;
	logic [14:0] taken [2] = '{15'h66a5, 15'h6a9a};
	exec_pkg::op_t ops [7] = '{exec_pkg::OP_BYTE_ORDER_SWAP_WORD,
		exec_pkg::OP_BYTE_ORDER_SWAP_HALVES,
		exec_pkg::OP_BYTE_ORDER_SWAP_SIGNED_HALF,
		exec_pkg::OP_SIGN_EXTEND_BYTE, exec_pkg::OP_SIGN_EXTEND_HALFWORD,
		exec_pkg::OP_ZERO_EXTEND_BYTE, exec_pkg::OP_ZERO_EXTEND_HALFWORD};
	logic [31:0] exps [7] = '{32'h8685_9988, 32'h9988_8685, 32'hffff_8685,
		32'hffff_ff86, 32'hffff_8586, 32'h0000_0086, 32'h0000_8586};
	int miscompares = 0, check_count = 0, i, j, k;

	always #2 clk_sys = ~clk_sys;

	move_mul_extend_branch_exec i_dut (.clk_sys, .nrst, .issue_valid,
		.issue_ready, .issue_op, .issue_rd, .issue_rn_val, .issue_rm_val,
		.issue_imm8, .issue_cond, .issue_offset, .issue_pc(32'h0000_1000),
		.wr_en, .wr_addr, .wr_data, .branch_valid, .branch_target,
		.unrecoverable_fault_exception, .cond_flags, .t_state, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
		.avs_readdata, .avs_waitrequest);
	reg_file_model i_rf (.clk_sys, .wr_en, .wr_addr, .wr_data,
		.rd_sel(4'he), .rd_val(rf_val));

	// ---------------------------------------------------------------
	// Access tasks
	// ---------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task conclude;
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	// Waits for the bus answer or for the issue port to take the request.
	task wait_ans(input logic on_bus);
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk_sys);
			if (on_bus ? avs_waitrequest === 1'b0 : issue_ready === 1'b1)
				break;
		end
		if (i == 40)
		begin
			chk(32'h0, 32'h1);
			conclude();
		end
	endtask : wait_ans

	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		wait_ans(1'b1);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// The condition code rides on the destination field; no op uses both.
	task run(input exec_pkg::op_t op, input logic [3:0] rd,
		input logic [31:0] rm, input logic [31:0] rn, input logic [24:0] x);
		@(posedge clk_sys);
		issue_valid <= 1'b1;
		issue_op <= op;
		issue_rd <= rd;
		issue_cond <= rd;
		issue_rm_val <= rm;
		issue_rn_val <= rn;
		issue_offset <= x;
		issue_imm8 <= x[7:0];
		wait_ans(1'b0);
		issue_valid <= 1'b0;
		#1;
	endtask : run

	task res(input logic w, input logic [31:0] wd, input logic [3:0] fl,
		input logic b, input logic [31:0] bt);
		chk(wr_en, w);
		if (w)
			chk(wr_data, wd);
		chk(cond_flags, fl);
		chk(branch_valid, b);
		if (b)
			chk(branch_target, bt);
	endtask : res

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		bus(1'b0, exec_pkg::ADDR_FLAGS, 32'h0);
		chk(q, 32'h10);
		bus(1'b0, 4'h2, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, exec_pkg::ADDR_FLAGS, 32'h13);
		run(exec_pkg::OP_COPY_REGISTER, 4'h2, 32'h8000_0000, 32'h0, 25'h0);
		res(1'b1, 32'h8000_0000, 4'h3, 1'b0, 32'h0);
		run(exec_pkg::OP_COPY_REGISTER_SETFLAGS, 4'h2, 32'h0, 32'h0, 25'h0);
		res(1'b1, 32'h0, 4'h7, 1'b0, 32'h0);
		run(exec_pkg::OP_COPY_INVERTED, 4'h2, 32'h0, 32'h0, 25'h0);
		res(1'b1, 32'hffff_ffff, 4'hb, 1'b0, 32'h0);
		run(exec_pkg::OP_COPY_IMMEDIATE, 4'h2, 32'h0, 32'h0, 25'h1ff);
		res(1'b1, 32'h0000_00ff, 4'h3, 1'b0, 32'h0);
		run(exec_pkg::OP_MULTIPLY_LOW_WORD, 4'h1, 32'hffff_fffe,
			32'hffff_ffff, 25'h0);
		res(1'b1, 32'h2, 4'h3, 1'b0, 32'h0);
		run(exec_pkg::OP_MULTIPLY_LOW_WORD, 4'h1, 32'h1_0000, 32'h1_0000,
			25'h0);
		res(1'b1, 32'h0, 4'h7, 1'b0, 32'h0);
		for (k = 0; k < 7; k++)
		begin
			run(ops[k], 4'h3, 32'h8899_8586, 32'h0, 25'h0);
			res(1'b1, exps[k], 4'h7, 1'b0, 32'h0);
		end
		run(exec_pkg::OP_BIT_TEST_AND, 4'h4, 32'h8000_00ff, 32'hf000_0000,
			25'h0);
		res(1'b0, 32'h0, 4'hb, 1'b0, 32'h0);
		run(exec_pkg::OP_BIT_TEST_AND, 4'h4, 32'hf0, 32'h0f, 25'h0);
		res(1'b0, 32'h0, 4'h7, 1'b0, 32'h0);
		bus(1'b1, exec_pkg::ADDR_FLAGS, 32'h07);
		run(exec_pkg::OP_COPY_REGISTER, 4'hf, 32'h1235, 32'h0, 25'h0);
		res(1'b0, 32'h0, 4'h7, 1'b1, 32'h1234);
		chk(t_state, 1'b0);
		run(exec_pkg::OP_BRANCH, 4'h0, 32'h0, 32'h0, 25'h1ff_f800);
		res(1'b0, 32'h0, 4'h7, 1'b1, 32'h0804);
		run(exec_pkg::OP_BRANCH, 4'h0, 32'h0, 32'h0, 25'h7fe);
		res(1'b0, 32'h0, 4'h7, 1'b1, 32'h1802);
		run(exec_pkg::OP_BRANCH_COND, 4'he, 32'h0, 32'h0, 25'h1ff_ff00);
		res(1'b0, 32'h0, 4'h7, 1'b1, 32'h0f04);
		run(exec_pkg::OP_BRANCH_COND, 4'he, 32'h0, 32'h0, 25'hfe);
		res(1'b0, 32'h0, 4'h7, 1'b1, 32'h1102);
		run(exec_pkg::OP_BRANCH_WITH_LINK, 4'h0, 32'h0, 32'h0, 25'h100_0000);
		res(1'b1, 32'h1005, 4'h7, 1'b1, 32'hff00_1004);
		chk(wr_addr, 4'he);
		run(exec_pkg::OP_BRANCH_WITH_LINK, 4'h0, 32'h0, 32'h0, 25'hff_fffe);
		res(1'b1, 32'h1005, 4'h7, 1'b1, 32'h0100_1002);
		chk(rf_val, 32'h1005);
		for (k = 0; k < 2; k++)
		begin
			bus(1'b1, exec_pkg::ADDR_FLAGS, k ? 32'h8 : 32'h6);
			for (j = 0; j < 15; j++)
			begin
				run(exec_pkg::OP_BRANCH_COND, j[3:0], 32'h0, 32'h0, 25'h10);
				res(1'b0, 32'h0, k ? 4'h8 : 4'h6, taken[k][j], 32'h1014);
			end
		end
		run(exec_pkg::OP_BRANCH_INDIRECT, 4'h0, 32'h2001, 32'h0, 25'h0);
		res(1'b0, 32'h0, 4'h8, 1'b1, 32'h2000);
		chk(t_state, 1'b1);
		run(exec_pkg::OP_BRANCH_INDIRECT_LINK, 4'h0, 32'h3001, 32'h0, 25'h0);
		res(1'b1, 32'h1003, 4'h8, 1'b1, 32'h3000);
		bus(1'b1, exec_pkg::ADDR_FLAGS, 32'h0);
		run(exec_pkg::OP_BRANCH_INDIRECT, 4'h0, 32'h4000, 32'h0, 25'h0);
		res(1'b0, 32'h0, 4'h0, 1'b0, 32'h0);
		chk(unrecoverable_fault_exception, 1'b1);
		chk(t_state, 1'b0);
		bus(1'b0, exec_pkg::ADDR_STATUS, 32'h0);
		chk(q[0], 1'b1);
		bus(1'b0, exec_pkg::ADDR_FAULT_PC, 32'h0);
		chk(q, 32'h1000);
		bus(1'b1, exec_pkg::ADDR_STATUS, 32'h1);
		bus(1'b0, exec_pkg::ADDR_STATUS, 32'h0);
		chk(q[0], 1'b0);
		bus(1'b1, exec_pkg::ADDR_CTRL, 32'h1);
		repeat (2) @(posedge clk_sys);
		#1;
		chk(issue_ready, 1'b0);
		bus(1'b1, exec_pkg::ADDR_CTRL, 32'h0);
		conclude();
	end
endmodule : move_mul_extend_branch_exec_bench
